/* File: design/dc_corr_pkg.sv */
// Package for the dc correction configuration block: offsets, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a 12-bit sample stream on the same clock.
package dc_corr_pkg;

  // Printed offsets are not multiples of four: they are indices, byte address = 4 * index
  localparam logic [7:0] IDX_DC_TARGET_SHIFT = 8'hBF;
  localparam logic [7:0] IDX_DC_LOOP_CONTROL = 8'hCF;
  localparam logic [7:0] IDX_RATE_RANGE = 8'hDF;
  localparam logic [7:0] IDX_HIGH_FREQ_TUNING = 8'h4A;
  localparam logic [7:0] IDX_DC_STATUS = 8'hE0;

  localparam logic [7:0] RST_DC_TARGET_SHIFT = 8'h00;
  localparam logic [7:0] RST_DC_LOOP_CONTROL = 8'h00;
  localparam logic [7:0] RST_RATE_RANGE = 8'h00;
  localparam logic [7:0] RST_HIGH_FREQ_TUNING = 8'h00;

  localparam int HF_TUNE_BIT = 0;
  localparam int PEDESTAL_LSB = 4;
  localparam int HOLD_BIT = 7;
  localparam int WINDOW_LSB = 2;
  localparam int CANCEL_EN_BIT = 0;
  localparam int LOW_RATE_LSB = 4;
  localparam logic [1:0] LOW_RATE_ON = 2'h3;
  localparam logic [3:0] WINDOW_MAX_CODE = 4'hB;
  localparam int WINDOW_BASE_LOG2 = 20;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic hf_tuning;
    logic cancel_enable;
    logic hold_estimate;
    logic [3:0] window_code;
    logic signed [3:0] pedestal;
    logic low_rate;
  } dc_cfg_s;

endpackage

/* File: design/dc_corr_regs.sv */
// Configuration registers and digital dc offset correction loop.
// Assumes samples arrive as two's-complement words synchronous to aclk.
// How it works
// - Bit 0 of its register selects high-frequency tuning; reset value zero.
// - With correction active, output converges toward mid-scale code.
// - Pedestal from dc target bits 7:4 is added to converged value.
// - Pedestal is signed two's complement, minus eight to plus seven LSB.
// - Hold bit 7 freezes the estimate; last estimate still applied.
// - Bits 5:2 pick averaging window, 1M cycles doubling up to 2G.
// - Low-rate mode on only when bits 5:4 equal 11; off after reset.
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module dc_corr_regs
  import dc_corr_pkg::*;
#(
  parameter int SAMPLE_W = 12,
  parameter int WINDOW_BASE = WINDOW_BASE_LOG2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [SAMPLE_W-1:0] sample_in,
  output logic [SAMPLE_W-1:0] sample_out,
  output dc_cfg_s cfg
);

  // Refused at elaboration: the accumulator and saturation limits assume these ranges
  if (SAMPLE_W < 6 || SAMPLE_W > 16 || WINDOW_BASE < 1 || WINDOW_BASE > 20) begin : g_bad
    $error("dc_corr_regs: unsupported SAMPLE_W or WINDOW_BASE");
  end

  localparam int ACC_W = SAMPLE_W + WINDOW_BASE + 12;

  logic [7:0] target_r;
  logic [7:0] loop_r;
  logic [7:0] rate_r;
  logic [7:0] tune_r;
  logic [7:0] enable_r;

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order, response follows both
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_idx_r;
  logic [7:0] wdata_r;
  logic wlane_r;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;

  wire do_write = aw_have_r && w_have_r;
  wire wr_hit = (aw_idx_r == IDX_DC_TARGET_SHIFT) || (aw_idx_r == IDX_DC_LOOP_CONTROL) ||
                (aw_idx_r == IDX_RATE_RANGE) || (aw_idx_r == IDX_HIGH_FREQ_TUNING) ||
                (aw_idx_r == IDX_DC_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_idx_r <= 8'h00;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_idx_r <= (s_axi_awaddr[31:10] == 22'h0) ? s_axi_awaddr[9:2] : 8'h00;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Registers; lane 0 only, as each register is eight bits wide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_r <= RST_DC_TARGET_SHIFT;
      loop_r <= RST_DC_LOOP_CONTROL;
      rate_r <= RST_RATE_RANGE;
      tune_r <= RST_HIGH_FREQ_TUNING;
      enable_r <= 8'h00;
    end else if (do_write && wlane_r) begin
      if (aw_idx_r == IDX_DC_TARGET_SHIFT) begin
        target_r <= wdata_r;
      end else if (aw_idx_r == IDX_DC_LOOP_CONTROL) begin
        loop_r <= wdata_r;
      end else if (aw_idx_r == IDX_RATE_RANGE) begin
        rate_r <= wdata_r;
      end else if (aw_idx_r == IDX_HIGH_FREQ_TUNING) begin
        tune_r <= wdata_r;
      end else if (aw_idx_r == IDX_DC_STATUS) begin
        enable_r <= wdata_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded configuration
  always_comb begin
    cfg.hf_tuning = tune_r[HF_TUNE_BIT];
    cfg.cancel_enable = enable_r[CANCEL_EN_BIT];
    cfg.hold_estimate = loop_r[HOLD_BIT];
    cfg.window_code = loop_r[WINDOW_LSB +: 4];
    cfg.pedestal = target_r[PEDESTAL_LSB +: 4];
    cfg.low_rate = (rate_r[LOW_RATE_LSB +: 2] == LOW_RATE_ON);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Correction loop: leaky average with shift 2^(base+code); reserved codes clamp to 1011
  logic signed [ACC_W-1:0] acc_r;
  logic signed [SAMPLE_W-1:0] est_r;
  logic [4:0] shift_t;
  logic signed [ACC_W-1:0] samp_ext;
  logic signed [SAMPLE_W+1:0] corr_t;
  logic signed [SAMPLE_W+1:0] lim_hi;
  logic signed [SAMPLE_W+1:0] lim_lo;

  always_comb begin
    shift_t = 5'(WINDOW_BASE) + ((cfg.window_code > WINDOW_MAX_CODE) ?
              {1'b0, WINDOW_MAX_CODE} : {1'b0, cfg.window_code});
    samp_ext = ACC_W'(signed'(sample_in));
    lim_hi = (SAMPLE_W+2)'({1'b0, {(SAMPLE_W-1){1'b1}}});
    lim_lo = -lim_hi - (SAMPLE_W+2)'(1);
    // Subtract estimate, add pedestal; mid-scale is zero in two's complement
    corr_t = (SAMPLE_W+2)'(signed'(sample_in)) - (SAMPLE_W+2)'(est_r)
             + (SAMPLE_W+2)'(cfg.pedestal);
  end

  // Accumulator holds estimate scaled by 2^shift; loses the estimate when disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg.cancel_enable) begin
      acc_r <= '0;
    end else if (!cfg.hold_estimate) begin
      acc_r <= acc_r + samp_ext - (acc_r >>> shift_t);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      est_r <= '0;
    end else begin
      est_r <= SAMPLE_W'(acc_r >>> shift_t);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_out <= '0;
    end else if (!cfg.cancel_enable) begin
      sample_out <= sample_in;
    end else if (corr_t > lim_hi) begin
      sample_out <= lim_hi[SAMPLE_W-1:0];
    end else if (corr_t < lim_lo) begin
      sample_out <= lim_lo[SAMPLE_W-1:0];
    end else begin
      sample_out <= corr_t[SAMPLE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read: one read at a time, answer one cycle after address taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr[31:10] != 22'h0) begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end else if (s_axi_araddr[9:2] == IDX_DC_TARGET_SHIFT) begin
        s_axi_rdata <= {24'h0, target_r};
      end else if (s_axi_araddr[9:2] == IDX_DC_LOOP_CONTROL) begin
        s_axi_rdata <= {24'h0, loop_r};
      end else if (s_axi_araddr[9:2] == IDX_RATE_RANGE) begin
        s_axi_rdata <= {24'h0, rate_r};
      end else if (s_axi_araddr[9:2] == IDX_HIGH_FREQ_TUNING) begin
        s_axi_rdata <= {24'h0, tune_r};
      end else if (s_axi_araddr[9:2] == IDX_DC_STATUS) begin
        s_axi_rdata <= {8'h00, 8'(SAMPLE_W'(est_r) >> (SAMPLE_W-8)), 8'h00, enable_r};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dc_corr_regs

/* File: testbench/dc_corr_assertions.sv */
// Port checker for dc_corr_regs.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module dc_corr_assertions
  import dc_corr_pkg::*;
#(parameter int SAMPLE_W = 12) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic [SAMPLE_W-1:0] sample_out,
  input wire dc_cfg_s cfg
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  sequence rd_of(logic [9:0] a);
    $rose(s_axi_rvalid) && $past(s_axi_araddr) == {22'h0, a};
  endsequence
  a_tune_readback: assert property (
    rd_of({IDX_HIGH_FREQ_TUNING, 2'h0}) |-> cfg.hf_tuning == s_axi_rdata[0])
    else $error("tuning flag differs from register");
  a_pedestal_field: assert property (
    rd_of({IDX_DC_TARGET_SHIFT, 2'h0}) |-> cfg.pedestal == s_axi_rdata[7:4])
    else $error("pedestal differs from register");
  a_loop_fields: assert property (
    rd_of({IDX_DC_LOOP_CONTROL, 2'h0}) |-> cfg.hold_estimate == s_axi_rdata[7]
    && cfg.window_code == s_axi_rdata[5:2]) else $error("loop fields differ");
  a_low_rate_code: assert property (
    rd_of({IDX_RATE_RANGE, 2'h0}) |-> cfg.low_rate == (s_axi_rdata[5:4] == 2'h3))
    else $error("low rate decode wrong");
  a_bypass_path: assert property (
    $past(aresetn) && !cfg.cancel_enable ##1 !cfg.cancel_enable
    |-> sample_out == $past(sample_in)) else $error("bypass sample wrong");
  // Frozen estimate: steady input and settings must give a steady output
  a_hold_steady: assert property (
    (cfg.cancel_enable && cfg.hold_estimate && $stable(sample_in) && $stable(cfg))[*4]
    |-> $stable(sample_out)) else $error("output moved while held");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  c_hold: cover property (cfg.cancel_enable && cfg.hold_estimate);
  c_low_rate: cover property (cfg.low_rate);
  c_neg_pedestal: cover property (cfg.pedestal[3]);
endmodule // dc_corr_assertions
bind dc_corr_regs dc_corr_assertions #(.SAMPLE_W(SAMPLE_W)) chk_u (.*);

/* File: testbench/dc_corr_regs_test.sv */
// Bench for dc_corr_regs: register access over AXI4-Lite and the sample path.
// Assumes WINDOW_BASE 2 so the loop settles in a few dozen cycles.
`timescale 1ns/1ns
module dc_corr_regs_test
  import dc_corr_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] sample_in, sample_out, o;
  dc_cfg_s cfg;
  int error_cnt, total_checks;
  logic [7:0] regs[4] = '{IDX_DC_TARGET_SHIFT, IDX_DC_LOOP_CONTROL, IDX_RATE_RANGE,
                          IDX_HIGH_FREQ_TUNING};
  logic [3:0] peds[3] = '{4'h0, 4'h7, 4'h8};
  dc_corr_regs #(.SAMPLE_W(12), .WINDOW_BASE(2)) dut_u (.*);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Loop output may sit a few LSB off its target after truncation
  task automatic near(input logic [11:0] g, input logic [11:0] e);
    bit ok;
    ok = 0;
    for (int k = -3; k <= 3; k++) if (g === 12'(e + k)) ok = 1;
    if (!ok) chk({20'h0, g}, {20'h0, e});
    else total_checks++;
  endtask
  // Handshakes are looked at on the falling edge: those values are what the next rising
  // edge samples, so no race with the design's own updates on that rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw_t, w_t, b_t;
    logic [1:0] resp;
    s_axi_awaddr <= {22'h0, a, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!b_t);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    chk({30'h0, resp}, {30'h0, r});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    logic ar_t, r_t;
    logic [31:0] data;
    logic [1:0] resp;
    s_axi_araddr <= {22'h0, a, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!r_t);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk({30'h0, resp}, {30'h0, r});
    if (r == RESP_OKAY) chk(data, e);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    #2000000;
    error_cnt++;
    results();
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    sample_in = 12'h123;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rdc(regs[i], 32'h0, RESP_OKAY);
    rdc(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 8'hFF, RESP_SLVERR);
    wr(IDX_HIGH_FREQ_TUNING, 8'h01, RESP_OKAY);
    chk({31'h0, cfg.hf_tuning}, 32'h1);
    rdc(IDX_HIGH_FREQ_TUNING, 32'h1, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_RATE_RANGE, {2'h0, 2'(i), 4'h0}, RESP_OKAY);
      chk({31'h0, cfg.low_rate}, {31'h0, i == 3});
      rdc(IDX_RATE_RANGE, {26'h0, 2'(i), 4'h0}, RESP_OKAY);
    end
    // Reserved codes 12 to 15 are stored as written; the loop clamps them internally
    for (int c = 0; c < 16; c++) begin
      wr(IDX_DC_LOOP_CONTROL, {2'h2, 4'(c), 2'h0}, RESP_OKAY);
      chk({27'h0, cfg.hold_estimate, cfg.window_code}, 32'h10 + c);
      rdc(IDX_DC_LOOP_CONTROL, {24'h0, 2'h2, 4'(c), 2'h0}, RESP_OKAY);
    end
    wr(IDX_DC_LOOP_CONTROL, 8'h00, RESP_OKAY);
    wr(IDX_DC_STATUS, 8'h01, RESP_OKAY);
    foreach (peds[i]) begin
      wr(IDX_DC_TARGET_SHIFT, {peds[i], 4'h0}, RESP_OKAY);
      rdc(IDX_DC_TARGET_SHIFT, {24'h0, peds[i], 4'h0}, RESP_OKAY);
      // Outputs are read mid-cycle, away from the edge that launches them
      repeat (150) @(negedge aclk);
      near(sample_out, {{8{peds[i][3]}}, peds[i]});
      @(posedge aclk);
    end
    // Settled estimate equals the steady input 0x123; its upper eight bits are 0x12
    rdc(IDX_DC_STATUS, 32'h0012_0001, RESP_OKAY);
    wr(IDX_DC_LOOP_CONTROL, 8'h80, RESP_OKAY);
    repeat (4) @(negedge aclk);
    o = sample_out;
    @(posedge aclk);
    sample_in <= 12'h143;
    repeat (6) @(negedge aclk);
    chk({20'h0, sample_out}, {20'h0, o + 12'h020});
    @(posedge aclk);
    wr(IDX_DC_STATUS, 8'h00, RESP_OKAY);
    repeat (3) @(negedge aclk);
    chk({20'h0, sample_out}, 32'h143);
    results();
  end
endmodule // dc_corr_regs_test
